/* dpm_pkg.sv */
// constants and types shared by the dac power, mute and volume block
// What this block does
// - left dac channel powers up when its power bit is 1; reset keeps it down
// - right dac channel powers up when its power bit is 1; reset keeps it down
// - soft-step field: 00 one step per fs, 01 per 2fs, 10 off, 11 reserved
// - right powered down: output zero, or inverted left output when select bit set
// - auto-mute off at 000; else mute after 100 up to 6400 dc inputs
// - left channel is muted while its mute bit is 1, the reset value
// - right channel is muted while its mute bit is 1, the reset value
// - master volume 00: each channel uses its own volume; 11 is reserved
// - master volume 01: right volume setting drives both channels
// - master volume 10: left volume setting drives both channels
// - left volume is signed half-db gain, +24 db to -63.5 db, resets to 0 db
// - right volume register at next offset uses the same encoding as left
package dpm_pkg;
  localparam int SAMPLE_W   = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int DC_CNT_W   = 13;

  // register offsets
  localparam logic [7:0] ADDR_PWR_SS    = 8'h3f;
  localparam logic [7:0] ADDR_MASTER    = 8'h40;
  localparam logic [7:0] ADDR_LEFT_VOL  = 8'h41;
  localparam logic [7:0] ADDR_RIGHT_VOL = 8'h42;

  // field positions
  localparam int PWR_L_BIT   = 7;
  localparam int PWR_R_BIT   = 6;
  localparam int MOD_INV_BIT = 7;
  localparam int AM_LSB      = 4;
  localparam int MUTE_L_BIT  = 3;
  localparam int MUTE_R_BIT  = 2;

  // values after reset, and the write mask of the power register
  localparam logic [7:0] PWR_SS_RST = 8'h00;
  localparam logic [7:0] MASTER_RST = 8'h0c;
  localparam logic [7:0] VOL_RST    = 8'h00;
  localparam logic [7:0] PWR_SS_WMASK = 8'hc3;

  // auto-mute threshold for code 001, doubled per code step
  localparam logic [DC_CNT_W-1:0] AM_BASE = 13'h0064;

  // gain arithmetic: half-db code offset, steps per 6 db, shift for unity
  localparam logic [8:0] GAIN_OFFSET = 9'h084;
  localparam logic [8:0] GAIN_STEPS  = 9'h00c;
  localparam logic [4:0] GAIN_SHIFT  = 5'h19;
  // q14 mantissas for 0..5.5 db in half-db steps
  localparam logic [11:0][15:0] GAIN_MANT = {16'h78d1, 16'h7209, 16'h6ba2,
    16'h6598, 16'h5fe4, 16'h5a82, 16'h556e, 16'h50a3, 16'h4c1c, 16'h47d6,
    16'h43ce, 16'h4000};

  typedef enum logic [1:0] {
    DPM_SS_EVERY_FS  = 2'h0,
    DPM_SS_EVERY_2FS = 2'h1,
    DPM_SS_OFF       = 2'h2,
    DPM_SS_RSVD      = 2'h3
  } dpm_softstep_t;

  typedef enum logic [1:0] {
    DPM_MV_INDEP = 2'h0,
    DPM_MV_RIGHT = 2'h1,
    DPM_MV_LEFT  = 2'h2,
    DPM_MV_RSVD  = 2'h3
  } dpm_master_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } dpm_sample_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpm_reg_req_t;

  typedef struct packed {
    logic [7:0] pwr_ss;
    logic [7:0] master;
    logic [7:0] left_vol;
    logic [7:0] right_vol;
  } dpm_regs_t;
endpackage

/* dpm_fifo.sv */
// parameterised sample fifo with valid/ready on both sides
module dpm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        full;
    logic                        empty;
    logic                        rdy;
  } dpm_fifo_state_t;

  dpm_fifo_state_t st_reg;
  dpm_fifo_state_t st_next;
  logic            push;
  logic            pop;

  // full and empty are kept as flops so ready leaves straight from a register
  always_comb begin
    st_next = st_reg;
    push    = in_valid_i && !st_reg.full;
    pop     = out_ready_i && !st_reg.empty;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data_i;
      st_next.wr_ptr             = AW'(st_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      st_next.rd_ptr = AW'(st_reg.rd_ptr + 1'b1);
    end
    st_next.count = (AW+1)'(st_reg.count + {AW'(0), push} - {AW'(0), pop});
    st_next.full  = (st_next.count == (AW+1)'(DEPTH));
    st_next.empty = (st_next.count == '0);
    st_next.rdy   = !st_next.full;
  end

  // synchronous reset leaves the fifo empty
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg       <= '0;
      st_reg.empty <= 1'b1;
      st_reg.rdy   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ready leaves straight from its own flop, no inverter on the port
  assign in_ready_o  = st_reg.rdy;
  assign out_valid_o = !st_reg.empty;
  assign out_data_o  = st_reg.mem[st_reg.rd_ptr];
endmodule

/* dpm_core.sv */
// dac power, mute, auto-mute and digital volume control with sample path
module dpm_core (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire dpm_pkg::dpm_reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire dpm_pkg::dpm_sample_t  sample_i,
  input  wire logic                  sample_valid_i,
  output logic                       sample_ready_o,
  output dpm_pkg::dpm_sample_t       sample_o,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output logic                       left_pwr_o,
  output logic                       right_pwr_o,
  output logic                       auto_mute_o
);
  import dpm_pkg::*;

  typedef struct packed {
    dpm_regs_t             regs;
    logic [7:0]            rdata;
    logic signed [7:0]     cur_l;
    logic signed [7:0]     cur_r;
    logic                  half;
    dpm_sample_t           prev;
    logic [DC_CNT_W-1:0]   dc_cnt;
    logic                  auto_mute;
    dpm_sample_t           out;
    logic                  out_valid;
  } dpm_core_state_t;

  dpm_core_state_t st_reg;
  dpm_core_state_t st_next;

  dpm_sample_t fifo_data;
  logic        fifo_valid;
  logic        take;

  // one half-db step toward the target, used for both channels
  function automatic logic signed [7:0] dpm_step(input logic signed [7:0] cur,
                                                 input logic signed [7:0] tgt);
    if (cur < tgt) begin
      dpm_step = 8'(cur + 8'sh01);
    end else if (cur > tgt) begin
      dpm_step = 8'(cur - 8'sh01);
    end else begin
      dpm_step = cur;
    end
  endfunction

  // gain is mantissa of the half-db remainder times a power of two per 6 db;
  // a 6 db step is taken as one octave, an error of about 0.02 db per octave
  function automatic logic signed [15:0] dpm_apply_gain(input logic signed [15:0] s,
                                                        input logic signed [7:0] g);
    logic [8:0]         gp;
    logic [3:0]         q;
    logic [3:0]         r;
    logic signed [32:0] prod;
    logic signed [32:0] sh;
    gp   = 9'({g[7], g} + GAIN_OFFSET);
    q    = 4'(gp / GAIN_STEPS);
    r    = 4'(gp % GAIN_STEPS);
    prod = s * $signed({1'b0, GAIN_MANT[r]});
    sh   = prod >>> (GAIN_SHIFT - {1'b0, q});
    if (sh > 33'sh07fff) begin
      dpm_apply_gain = 16'sh7fff;
    end else if (sh < -33'sh08000) begin
      dpm_apply_gain = 16'sh8000;
    end else begin
      dpm_apply_gain = 16'(sh);
    end
  endfunction

  // register read decode; unmapped offsets read as zero
  function automatic logic [7:0] dpm_read(input dpm_regs_t r, input logic [7:0] a);
    case (a)
      ADDR_PWR_SS:    dpm_read = r.pwr_ss;
      ADDR_MASTER:    dpm_read = r.master;
      ADDR_LEFT_VOL:  dpm_read = r.left_vol;
      ADDR_RIGHT_VOL: dpm_read = r.right_vol;
      default:        dpm_read = 8'h00;
    endcase
  endfunction

  // sixteen-sample buffer; when it is full the source is held off
  dpm_fifo #(
    .WIDTH ($bits(dpm_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (sample_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (take)
  );

  // each sample taken from the fifo is one fs period
  assign take = fifo_valid && (!st_reg.out_valid || out_ready_i);

  // decoded control fields
  logic              pwr_l;
  logic              pwr_r;
  logic              mod_inv;
  logic [2:0]        am_code;
  logic              mute_l;
  logic              mute_r;
  dpm_softstep_t     ss_mode;
  dpm_master_t       mv_mode;
  logic signed [7:0] tgt_l;
  logic signed [7:0] tgt_r;
  logic [DC_CNT_W-1:0] am_thr;

  always_comb begin
    pwr_l   = st_reg.regs.pwr_ss[PWR_L_BIT];
    pwr_r   = st_reg.regs.pwr_ss[PWR_R_BIT];
    ss_mode = dpm_softstep_t'(st_reg.regs.pwr_ss[1:0]);
    mod_inv = st_reg.regs.master[MOD_INV_BIT];
    am_code = st_reg.regs.master[AM_LSB +: 3];
    mute_l  = st_reg.regs.master[MUTE_L_BIT];
    mute_r  = st_reg.regs.master[MUTE_R_BIT];
    mv_mode = dpm_master_t'(st_reg.regs.master[1:0]);
    am_thr  = (am_code == 3'h0) ? '0 : DC_CNT_W'(AM_BASE << (am_code - 3'h1));
    // volume linking; the reserved code falls back to independent
    case (mv_mode)
      DPM_MV_RIGHT: begin
        tgt_l = st_reg.regs.right_vol;
        tgt_r = st_reg.regs.right_vol;
      end
      DPM_MV_LEFT: begin
        tgt_l = st_reg.regs.left_vol;
        tgt_r = st_reg.regs.left_vol;
      end
      default: begin
        tgt_l = st_reg.regs.left_vol;
        tgt_r = st_reg.regs.right_vol;
      end
    endcase
  end

  // next-state logic: registers, soft-step, dc detect and output stage
  always_comb begin
    logic [DC_CNT_W-1:0] cnt_new;
    logic                am_new;
    logic signed [15:0]  gl;
    logic signed [15:0]  gr;
    logic signed [15:0]  lo;
    logic signed [15:0]  ro;
    st_next = st_reg;
    cnt_new = st_reg.dc_cnt;
    am_new  = st_reg.auto_mute;
    gl      = dpm_apply_gain(fifo_data.left, st_reg.cur_l);
    gr      = dpm_apply_gain(fifo_data.right, st_reg.cur_r);
    lo      = '0;
    ro      = '0;

    // host writes at the printed offsets; reserved bits stay zero
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_PWR_SS:    st_next.regs.pwr_ss = reg_req_i.wdata & PWR_SS_WMASK;
        ADDR_MASTER:    st_next.regs.master = reg_req_i.wdata;
        ADDR_LEFT_VOL:  st_next.regs.left_vol = reg_req_i.wdata;
        ADDR_RIGHT_VOL: st_next.regs.right_vol = reg_req_i.wdata;
        default:        st_next.regs = st_reg.regs;
      endcase
    end
    if (reg_req_i.rd) begin
      st_next.rdata = dpm_read(st_reg.regs, reg_req_i.addr);
    end

    // output word is held until the sink takes it
    if (st_reg.out_valid && out_ready_i) begin
      st_next.out_valid = 1'b0;
    end

    // soft-step disabled (or reserved code): gain follows target at once
    if (ss_mode == DPM_SS_OFF || ss_mode == DPM_SS_RSVD) begin
      st_next.cur_l = tgt_l;
      st_next.cur_r = tgt_r;
    end

    if (take) begin
      // dc run length; any change restarts it and releases the mute
      if (fifo_data == st_reg.prev) begin
        if (st_reg.dc_cnt != '1) begin
          cnt_new = DC_CNT_W'(st_reg.dc_cnt + 1'b1);
        end
      end else begin
        cnt_new = '0;
      end
      am_new = (am_code != 3'h0) && (cnt_new >= am_thr);
      st_next.dc_cnt    = cnt_new;
      st_next.auto_mute = am_new;
      st_next.prev      = fifo_data;

      // soft-step at one step per fs or per two fs
      st_next.half = !st_reg.half;
      if (ss_mode == DPM_SS_EVERY_FS || (ss_mode == DPM_SS_EVERY_2FS && st_reg.half)) begin
        st_next.cur_l = dpm_step(st_reg.cur_l, tgt_l);
        st_next.cur_r = dpm_step(st_reg.cur_r, tgt_r);
      end

      // left path: power, mute and auto-mute force silence
      if (pwr_l && !mute_l && !am_new) begin
        lo = gl;
      end
      // right path; powered down it mirrors the left modulator or sits at zero
      if (pwr_r) begin
        if (!mute_r && !am_new) begin
          ro = gr;
        end
      end else if (mod_inv) begin
        ro = (lo == 16'sh8000) ? 16'sh7fff : 16'(-lo);
      end
      st_next.out.left  = lo;
      st_next.out.right = ro;
      st_next.out_valid = 1'b1;
    end
  end

  // synchronous reset loads the documented register values
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg             <= '0;
      st_reg.regs.pwr_ss <= PWR_SS_RST;
      st_reg.regs.master <= MASTER_RST;
      st_reg.regs.left_vol  <= VOL_RST;
      st_reg.regs.right_vol <= VOL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign sample_o    = st_reg.out;
  assign out_valid_o = st_reg.out_valid;
  assign left_pwr_o  = st_reg.regs.pwr_ss[PWR_L_BIT];
  assign right_pwr_o = st_reg.regs.pwr_ss[PWR_R_BIT];
  assign auto_mute_o = st_reg.auto_mute;

  // checks on the behaviour above
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence pwr_write_s;
    reg_req_i.wr && reg_req_i.addr == ADDR_PWR_SS;
  endsequence

  sequence taken_off_s;
    take && ss_mode == DPM_SS_OFF;
  endsequence

  left_power_a: assert property (pwr_write_s |=> left_pwr_o == $past(reg_req_i.wdata[7]))
    else $error("left power bit did not follow the write");
  right_power_a: assert property (pwr_write_s |=> right_pwr_o == $past(reg_req_i.wdata[6]))
    else $error("right power bit did not follow the write");
  reserved_zero_a: assert property (pwr_write_s |=> st_reg.regs.pwr_ss[5:2] == 4'h0)
    else $error("reserved power bits not zero");
  step_off_a: assert property (taken_off_s |=> st_reg.cur_l == $past(tgt_l))
    else $error("gain did not jump with soft-step off");
  step_one_a: assert property (take && ss_mode == DPM_SS_EVERY_FS && st_reg.cur_l < tgt_l
                               && !reg_req_i.wr |=> st_reg.cur_l == $past(st_reg.cur_l) + 8'sh01)
    else $error("soft-step did not move one step");
  right_down_a: assert property (take && !pwr_r && !mod_inv |=> sample_o.right == 16'sh0000)
    else $error("powered-down right output not zero");
  // judged on the new word; the most negative left value saturates on negation
  right_mirror_a: assert property (take && !pwr_r && mod_inv |=> out_valid_o &&
                                   ((sample_o.left == 16'sh8000) ? (sample_o.right == 16'sh7fff)
                                    : (sample_o.right == -sample_o.left)))
    else $error("right output not inverted left");
  left_mute_a: assert property (take && mute_l |=> out_valid_o && sample_o.left == 16'sh0000)
    else $error("muted left output not zero");
  right_mute_a: assert property (take && pwr_r && mute_r |=> sample_o.right == 16'sh0000)
    else $error("muted right output not zero");
  // mute is decided per sample, so a later code change only counts at the next sample
  auto_mute_thr_a: assert property (take |=> auto_mute_o == ($past(am_code) != 3'h0 &&
                                    st_reg.dc_cnt >= DC_CNT_W'(AM_BASE << ($past(am_code) - 3'h1))))
    else $error("auto-mute does not match the dc run length");
  dc_release_a: assert property (take && fifo_data != st_reg.prev |=> !auto_mute_o
                                 && st_reg.dc_cnt == '0)
    else $error("dc count not restarted on change");
  link_indep_a: assert property (mv_mode == DPM_MV_INDEP && ss_mode == DPM_SS_OFF |=>
                                 st_reg.cur_r == $past(st_reg.regs.right_vol))
    else $error("independent mode mixes volumes");
  link_right_a: assert property (mv_mode == DPM_MV_RIGHT && ss_mode == DPM_SS_OFF |=>
                                 st_reg.cur_l == $past(st_reg.regs.right_vol))
    else $error("left not linked to right volume");
  link_left_a: assert property (mv_mode == DPM_MV_LEFT && ss_mode == DPM_SS_OFF |=>
                                st_reg.cur_r == $past(st_reg.regs.left_vol))
    else $error("right not linked to left volume");
  unity_gain_a: assert property (take && st_reg.cur_l == 8'sh00 && pwr_l && !mute_l
                                 && fifo_data != st_reg.prev |=> sample_o.left == $past(fifo_data.left))
    else $error("0 db gain altered the left sample");
  right_vol_a: assert property (reg_req_i.wr && reg_req_i.addr == ADDR_RIGHT_VOL |=>
                                st_reg.regs.right_vol == $past(reg_req_i.wdata))
    else $error("right volume write lost");
endmodule

/* dpm_host.sv */
// host model that programs the codec control registers
module dpm_host (
  input  wire logic          clk_i,
  output dpm_pkg::dpm_reg_req_t reg_req_o,
  input  wire logic [7:0]    reg_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import dpm_pkg::*;

  // bus idle until the first request
  initial reg_req_o = '{1'b0, 1'b0, 8'h00, 8'h00};

  // one write strobe; reserved power bits and out-of-range volume codes are made legal before they leave the host
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic vol;
    vol = (a == ADDR_LEFT_VOL) || (a == ADDR_RIGHT_VOL);
    @(posedge clk_i);
    #1;
    if (a == ADDR_PWR_SS) d = d & PWR_SS_WMASK;
    if (vol && d > 8'h30 && d < 8'h80) d = 8'h30;
    if (vol && d == 8'h80) d = 8'h81;
    reg_req_o = '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    #1;
    // released lines show a changed pattern, not the last value
    reg_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask

  // one read strobe; data is taken a full cycle after the strobe edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_req_o = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    #1;
    reg_req_o = '{1'b0, 1'b0, ~a, 8'hff};
    @(posedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule

/* dpm_core_tb.sv */
// self-checking bench for the dac power, mute and volume block
module dpm_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpm_pkg::*;
  localparam time DLY = 1ns;

  logic         clk_i;
  logic         reset_n_i;
  dpm_reg_req_t reg_req_i;
  logic [7:0]   reg_rdata_o;
  dpm_sample_t  sample_i;
  logic         sample_valid_i;
  logic         sample_ready_o;
  dpm_sample_t  sample_o;
  logic         out_valid_o;
  logic         out_ready_i;
  logic         left_pwr_o;
  logic         right_pwr_o;
  logic         auto_mute_o;
  dpm_sample_t  got_q[$];
  int           failures = 0;
  int           compares = 0;

  dpm_core i_dpm_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .sample_o(sample_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .left_pwr_o(left_pwr_o), .right_pwr_o(right_pwr_o),
    .auto_mute_o(auto_mute_o));
  dpm_host i_dpm_host (.clk_i(clk_i), .reg_req_o(reg_req_i), .reg_rdata_i(reg_rdata_o));

  // 25 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // sink records every word the block hands over
  always @(posedge clk_i) begin
    if (reset_n_i && out_valid_o && out_ready_i) got_q.push_back(sample_o);
  end

  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up;
    failures++;
    final_report();
  endtask

  function automatic dpm_sample_t smp(input logic [15:0] l, input logic [15:0] r);
    return '{l, r};
  endfunction

  // write, then let one edge pass so the new setting is in force
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_dpm_host.write(a, d);
    @(posedge clk_i);
    #DLY;
  endtask

  // offer the same word until n have been taken
  task automatic send_n(input dpm_sample_t s, input int n);
    int cnt = 0;
    int guard = 0;
    @(posedge clk_i);
    #DLY;
    sample_i = s;
    sample_valid_i = 1'b1;
    while (cnt < n) begin
      @(posedge clk_i);
      if (sample_ready_o === 1'b1) cnt++;
      guard++;
      if (guard > 4 * n + 50) give_up();
    end
    #DLY;
    sample_valid_i = 1'b0;
    sample_i = ~s;
  endtask

  task automatic collect(input int n);
    int guard = 0;
    while (got_q.size() < n) begin
      @(posedge clk_i);
      guard++;
      if (guard > 2 * n + 200) give_up();
    end
    #DLY;
  endtask

  task automatic xfer(input dpm_sample_t s, input dpm_sample_t exp);
    got_q.delete();
    send_n(s, 1);
    collect(1);
    check(got_q[0], exp);
  endtask

  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] adr [5] = '{ADDR_PWR_SS, ADDR_MASTER, ADDR_LEFT_VOL, ADDR_RIGHT_VOL, 8'h43};
    logic [7:0] rst [5] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      i_dpm_host.read(adr[i], d);
      check(d, rst[i]);
    end
    check(left_pwr_o, 1'b0);
    check(right_pwr_o, 1'b0);
  endtask

  task automatic t_power;
    logic [7:0] d;
    wr(ADDR_PWR_SS, 8'h82);
    check(left_pwr_o, 1'b1);
    check(right_pwr_o, 1'b0);
    wr(ADDR_PWR_SS, 8'h42);
    check(left_pwr_o, 1'b0);
    check(right_pwr_o, 1'b1);
    wr(ADDR_PWR_SS, 8'hc2);
    i_dpm_host.read(ADDR_PWR_SS, d);
    check(d, 8'hc2);
  endtask

  task automatic t_mute;
    xfer(smp(16'h1000, 16'h0200), smp(16'h0000, 16'h0000));
    wr(ADDR_MASTER, 8'h08);
    xfer(smp(16'h1000, 16'h0200), smp(16'h0000, 16'h0200));
    wr(ADDR_MASTER, 8'h04);
    xfer(smp(16'h1000, 16'h0200), smp(16'h1000, 16'h0000));
    wr(ADDR_MASTER, 8'h00);
    xfer(smp(16'h1000, 16'h0200), smp(16'h1000, 16'h0200));
  endtask

  // +6 db doubles, -6 db halves; master field picks whose setting counts
  task automatic t_volume;
    logic [7:0] d;
    wr(ADDR_LEFT_VOL, 8'h0c);
    wr(ADDR_RIGHT_VOL, 8'hf4);
    xfer(smp(16'h1000, 16'h0200), smp(16'h2000, 16'h0100));
    wr(ADDR_MASTER, 8'h01);
    xfer(smp(16'h1000, 16'h0200), smp(16'h0800, 16'h0100));
    wr(ADDR_MASTER, 8'h02);
    xfer(smp(16'h1000, 16'h0200), smp(16'h2000, 16'h0400));
    i_dpm_host.read(ADDR_RIGHT_VOL, d);
    check(d, 8'hf4);
  endtask

  task automatic t_mirror;
    wr(ADDR_MASTER, 8'h00);
    wr(ADDR_LEFT_VOL, 8'h00);
    wr(ADDR_RIGHT_VOL, 8'h00);
    wr(ADDR_PWR_SS, 8'h82);
    xfer(smp(16'h1000, 16'h0200), smp(16'h1000, 16'h0000));
    wr(ADDR_MASTER, 8'h80);
    xfer(smp(16'h1000, 16'h0200), smp(16'h1000, 16'hf000));
    wr(ADDR_MASTER, 8'h00);
  endtask

  // gain may only walk 0 -> +6 db one half-db step per one or two samples
  task automatic t_softstep;
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_PWR_SS, 8'hc2);
      wr(ADDR_LEFT_VOL, 8'h00);
      wr(ADDR_PWR_SS, 8'hc0 | 8'(m));
      wr(ADDR_LEFT_VOL, 8'h0c);
      got_q.delete();
      send_n(smp(16'h1000, 16'h0000), 26);
      collect(26);
      check(got_q[0].left, 16'h1000);
      check(got_q[m ? 22 : 11].left === 16'h2000, 1'b0);
      check(got_q[m ? 24 : 12].left, 16'h2000);
      check(auto_mute_o, 1'b0);
    end
    wr(ADDR_PWR_SS, 8'hc2);
    wr(ADDR_LEFT_VOL, 8'h00);
  endtask

  // every threshold: not muted at t repeats, muted beyond, released on change
  task automatic t_automute;
    int t;
    dpm_sample_t v;
    dpm_sample_t r;
    for (int c = 1; c < 8; c++) begin
      t = 100 << (c - 1);
      v = smp(16'h0100 + 16'(c), 16'h0000);
      r = smp(16'h0200 + 16'(c), 16'h0000);
      wr(ADDR_MASTER, {1'b0, 3'(c), 4'h0});
      got_q.delete();
      send_n(v, t);
      collect(t);
      check(auto_mute_o, 1'b0);
      xfer(v, smp(16'h0000, 16'h0000));
      check(auto_mute_o, 1'b1);
      xfer(v, smp(16'h0000, 16'h0000));
      xfer(r, r);
      check(auto_mute_o, 1'b0);
      got_q.delete();
      send_n(r, t - 1);
      collect(t - 1);
      check(auto_mute_o, 1'b0);
      check(got_q[t - 2], r);
    end
    wr(ADDR_MASTER, 8'h00);
  endtask

  // stall the sink, fill until refused, then drain in order
  task automatic t_fifo;
    int acc = 0;
    @(posedge clk_i);
    #DLY;
    out_ready_i = 1'b0;
    got_q.delete();
    sample_i = smp(16'h0010, 16'h0000);
    sample_valid_i = 1'b1;
    for (int g = 0; g < 40; g++) begin
      @(posedge clk_i);
      if (sample_ready_o === 1'b1) acc++;
      #DLY;
      sample_i = smp(16'h0010 + 16'(acc), 16'h0000);
    end
    sample_valid_i = 1'b0;
    check(sample_ready_o, 1'b0);
    check(acc >= FIFO_DEPTH, 1'b1);
    out_ready_i = 1'b1;
    collect(acc);
    for (int k = 0; k < acc; k++) check(got_q[k], smp(16'h0010 + 16'(k), 16'h0000));
    check(sample_ready_o, 1'b1);
  endtask

  // reset for two cycles, then run every scenario
  initial begin
    reset_n_i = 1'b0;
    sample_valid_i = 1'b0;
    sample_i = '0;
    out_ready_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #DLY;
    reset_n_i = 1'b1;
    t_reset();
    t_power();
    t_mute();
    t_volume();
    t_mirror();
    t_softstep();
    t_automute();
    t_fifo();
    final_report();
  end
endmodule
